/* File: design/rpt_consts.svh */
// Operation
// - Manual reset held low with supply good forces reset output low.
// - After manual reset releases, output stays low for full selected timeout.
// - Strap low selects 15 ms timeout; strap high selects 200 ms timeout.
// - Timeout starts once sense input rises above threshold plus hysteresis; release after it.
// - Sense below falling threshold drives reset output low at once.
// - Recovery needs sense above threshold plus hysteresis, not falling level.
`ifndef RPT_CONSTS_SVH
`define RPT_CONSTS_SVH
`define RPT_CLK_HZ 25000000
`define RPT_SHORT_MS 15
`define RPT_LONG_MS 200
`define RPT_SHORT_CYC ((`RPT_CLK_HZ / 1000) * `RPT_SHORT_MS)
`define RPT_LONG_CYC ((`RPT_CLK_HZ / 1000) * `RPT_LONG_MS)
`define RPT_CNT_W 23
`endif

/* File: design/rpt_pkg.sv */
package rpt_pkg;
    typedef enum logic [1:0] {RPT_HOLD, RPT_TIMING, RPT_RUN} rpt_state_type;
    typedef struct packed {
        logic manual_reset_n;
        logic sense_above_fall;
        logic sense_above_hyst;
        logic timeout_select;
    } rpt_in_type;
endpackage

/* File: design/rpt_sync.sv */
`timescale 1ns/1ps
module rpt_sync
    import rpt_pkg::*;
(
    input wire logic i_clock,
    input wire logic i_nrst,
    input wire rpt_in_type i_raw,
    output rpt_in_type o_sync
);
    rpt_in_type stage1;
    // Two-flop synchroniser; all-zero reset levels read as button held and undervoltage, keeping output low
    always_ff @(posedge i_clock) begin
        if (!i_nrst) begin
            stage1 <= '0;
            o_sync <= '0;
        end else begin
            stage1 <= i_raw;
            o_sync <= stage1;
        end
    end
endmodule

/* File: design/rpt_top.sv */
`timescale 1ns/1ps
`include "rpt_consts.svh"
module rpt_top
    import rpt_pkg::*;
#(
    parameter int SHORT_CYC = `RPT_SHORT_CYC,
    parameter int LONG_CYC = `RPT_LONG_CYC
)
(
    // Clock and reset
    input wire logic I_CLOCK,
    input wire logic I_NRST,
    // Pins
    input wire logic I_MANUAL_RESET_N,
    input wire logic I_SENSE_ABOVE_FALL,
    input wire logic I_SENSE_ABOVE_HYST,
    input wire logic I_TIMEOUT_SELECT,
    // Reset output
    output logic O_RESET_N
);
    rpt_in_type raw;
    rpt_in_type pin;
    rpt_state_type state;
    logic [`RPT_CNT_W-1:0] count;
    logic [`RPT_CNT_W-1:0] limit;
    logic cause;
    logic recovered;
    logic [`RPT_CNT_W-1:0] quiet_len;

    assign raw = '{manual_reset_n: I_MANUAL_RESET_N,
                   sense_above_fall: I_SENSE_ABOVE_FALL,
                   sense_above_hyst: I_SENSE_ABOVE_HYST,
                   timeout_select: I_TIMEOUT_SELECT};

    rpt_sync u_sync (
        .i_clock(I_CLOCK),
        .i_nrst(I_NRST),
        .i_raw(raw),
        .o_sync(pin)
    );

    // Timeout length from the strap
    assign limit = pin.timeout_select ? `RPT_CNT_W'(LONG_CYC - 1)
                                      : `RPT_CNT_W'(SHORT_CYC - 1);
    // Any reset cause present
    assign cause = !pin.manual_reset_n || !pin.sense_above_fall;
    // Recovery needs hysteresis level
    assign recovered = pin.manual_reset_n && pin.sense_above_hyst;

    // Sequencer
    always_ff @(posedge I_CLOCK) begin
        if (!I_NRST) begin
            state <= RPT_HOLD;
        end else begin
            case (state)
                RPT_HOLD: begin
                    if (recovered) begin
                        state <= RPT_TIMING;
                    end
                end
                RPT_TIMING: begin
                    if (cause || !recovered) begin
                        state <= RPT_HOLD;
                    end else if (count >= limit) begin
                        state <= RPT_RUN;
                    end
                end
                RPT_RUN: begin
                    if (cause) begin
                        state <= RPT_HOLD;
                    end
                end
                default: begin
                    state <= RPT_HOLD;
                end
            endcase
        end
    end

    // Timeout counter, cleared outside the timing state
    always_ff @(posedge I_CLOCK) begin
        if (!I_NRST) begin
            count <= '0;
        end else if (state == RPT_TIMING && !cause && recovered) begin
            count <= count + `RPT_CNT_W'(1);
        end else begin
            count <= '0;
        end
    end

    // Output low except when running
    always_ff @(posedge I_CLOCK) begin
        if (!I_NRST) begin
            O_RESET_N <= 1'b0;
        end else begin
            O_RESET_N <= (state == RPT_RUN && !cause) ||
                         (state == RPT_TIMING && !cause && recovered &&
                          count >= limit);
        end
    end

    // Cycles in a row with recovery met and no cause, for checking
    always_ff @(posedge I_CLOCK) begin
        if (!I_NRST) begin
            quiet_len <= '0;
        end else if (cause || !recovered) begin
            quiet_len <= '0;
        end else if (quiet_len != '1) begin
            quiet_len <= quiet_len + `RPT_CNT_W'(1);
        end
    end

    // Steps of recovery, restart and drop
    sequence s_recovery;
        state == RPT_HOLD && recovered;
    endsequence

    sequence s_held_low;
        !O_RESET_N [*8];
    endsequence

    sequence s_cause_in_timing;
        state == RPT_TIMING && cause;
    endsequence

    sequence s_cleared;
        state == RPT_HOLD && count == '0;
    endsequence

    sequence s_cause_in_run;
        state == RPT_RUN && cause;
    endsequence

    sequence s_dropped;
        state == RPT_HOLD && !O_RESET_N;
    endsequence

    property p_manual_low;
        @(posedge I_CLOCK) disable iff (!I_NRST)
        !pin.manual_reset_n |=> !O_RESET_N;
    endproperty
    a_manual_low: assert property (p_manual_low)
        else $error("reset output high while button held");

    property p_under_low;
        @(posedge I_CLOCK) disable iff (!I_NRST)
        !pin.sense_above_fall |=> !O_RESET_N;
    endproperty
    a_under_low: assert property (p_under_low)
        else $error("undervoltage did not force reset low");

    property p_rise_from_timing;
        @(posedge I_CLOCK) disable iff (!I_NRST)
        $rose(O_RESET_N) |-> $past(state) == RPT_TIMING;
    endproperty
    a_rise_from_timing: assert property (p_rise_from_timing)
        else $error("reset released without timeout");

    property p_hyst;
        @(posedge I_CLOCK) disable iff (!I_NRST)
        (state == RPT_HOLD && !pin.sense_above_hyst) |=> state == RPT_HOLD;
    endproperty
    a_hyst: assert property (p_hyst)
        else $error("timeout started below hysteresis level");

    property p_restart;
        @(posedge I_CLOCK) disable iff (!I_NRST)
        s_cause_in_timing |=> s_cleared;
    endproperty
    a_restart: assert property (p_restart)
        else $error("timeout not restarted");

    property p_limit;
        @(posedge I_CLOCK) disable iff (!I_NRST)
        (state == RPT_TIMING && $stable(limit)) |-> count <= limit;
    endproperty
    a_limit: assert property (p_limit)
        else $error("count beyond selected timeout");

    property p_start;
        @(posedge I_CLOCK) disable iff (!I_NRST)
        s_recovery |=> state == RPT_TIMING && count == '0;
    endproperty
    a_start: assert property (p_start)
        else $error("timeout did not start");

    property p_run_high;
        @(posedge I_CLOCK) disable iff (!I_NRST)
        (state == RPT_RUN && !cause) |-> O_RESET_N;
    endproperty
    a_run_high: assert property (p_run_high)
        else $error("reset low in run state");

    property p_full_timeout;
        @(posedge I_CLOCK) disable iff (!I_NRST)
        $rose(O_RESET_N) |-> quiet_len > limit;
    endproperty
    a_full_timeout: assert property (p_full_timeout)
        else $error("reset released before full timeout");

    property p_start_low;
        @(posedge I_CLOCK) disable iff (!I_NRST)
        s_recovery |=> s_held_low;
    endproperty
    a_start_low: assert property (p_start_low)
        else $error("reset output rose at start of timeout");

    property p_run_drop;
        @(posedge I_CLOCK) disable iff (!I_NRST)
        s_cause_in_run |=> s_dropped;
    endproperty
    a_run_drop: assert property (p_run_drop)
        else $error("cause in run did not drop reset output");

    property p_band_hold;
        @(posedge I_CLOCK) disable iff (!I_NRST)
        (state == RPT_RUN && !cause && !pin.sense_above_hyst) |=> O_RESET_N;
    endproperty
    a_band_hold: assert property (p_band_hold)
        else $error("reset output dropped inside hysteresis band");

    property p_timing_drop;
        @(posedge I_CLOCK) disable iff (!I_NRST)
        (state == RPT_TIMING && !pin.sense_above_hyst) |=> s_cleared;
    endproperty
    a_timing_drop: assert property (p_timing_drop)
        else $error("timeout kept running below hysteresis level");
endmodule

/* File: sim/rpt_far_end.sv */
`timescale 1ns/1ps
module rpt_far_end (
    // Commands
    input wire logic i_press,
    input wire logic [1:0] i_level,
    // Pins
    output logic o_manual_reset_n,
    output logic o_above_fall,
    output logic o_above_hyst
);
    // Button pulls low; level 0 under, 1 in band, 2 good
    assign o_manual_reset_n = !i_press;
    assign o_above_fall = i_level != 2'h0;
    assign o_above_hyst = i_level == 2'h2;
endmodule

/* File: sim/tb_rpt_top.sv */
`timescale 1ns/1ps
module tb_rpt_top;
    logic clk = 0, nrst = 0, press = 0, sel = 0, rst_n, mr_n, af, ah;
    logic [1:0] lvl = 2'h2;
    int n_mismatch = 0, n_tests = 0, cyc = 0, n;
    rpt_far_end u_far (.i_press(press), .i_level(lvl),
        .o_manual_reset_n(mr_n), .o_above_fall(af), .o_above_hyst(ah));
    rpt_top #(.SHORT_CYC(20), .LONG_CYC(50)) u_dut (.I_CLOCK(clk),
        .I_NRST(nrst), .I_MANUAL_RESET_N(mr_n), .I_SENSE_ABOVE_FALL(af),
        .I_SENSE_ABOVE_HYST(ah), .I_TIMEOUT_SELECT(sel), .O_RESET_N(rst_n));
    initial forever #20 clk = ~clk;
    task automatic final_report();
        $display("Checks %0d, mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            n_mismatch++;
            final_report();
        end
    end
    task automatic check(string what, logic got, logic exp);
        n_tests++;
        if (got !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED %s exp %b got %b", what, exp, got);
        end
    endtask
    task automatic drive(logic p, logic [1:0] l, logic s, int w);
        @(posedge clk);
        press <= p;
        lvl <= l;
        sel <= s;
        repeat (w) @(posedge clk);
        #1;
    endtask
    // Cycles from release edge until output high
    task automatic measure(string what, int lim);
        n = 0;
        while (rst_n !== 1'b1 && n < 200) begin
            @(posedge clk);
            #1;
            n++;
        end
        check({what, " early"}, n >= lim, 1'b1);
        check({what, " late"}, n <= lim + 8, 1'b1);
        $display("Test %s done", what);
    endtask
    task automatic t_manual(logic s);
        drive(1, 2'h2, s, 6);
        check("press low", rst_n, 1'b0);
        drive(0, 2'h2, s, 0);
        measure("manual", s ? 50 : 20);
    endtask
    task automatic t_sense();
        drive(0, 2'h0, 0, 6);
        check("undervolt low", rst_n, 1'b0);
        drive(0, 2'h1, 0, 80);
        check("in band low", rst_n, 1'b0);
        drive(0, 2'h2, 0, 8);
        drive(0, 2'h1, 0, 6);
        check("band drop low", rst_n, 1'b0);
        drive(0, 2'h2, 0, 0);
        measure("sense", 20);
    endtask
    task automatic t_band();
        drive(0, 2'h1, 0, 6);
        check("band keeps high", rst_n, 1'b1);
        $display("Test band done");
    endtask
    task automatic t_reset();
        @(posedge clk);
        nrst <= 1'b0;
        repeat (3) @(posedge clk);
        #1;
        check("reset low", rst_n, 1'b0);
        @(posedge clk);
        nrst <= 1'b1;
        #1;
        measure("reset", 20);
    endtask
    task automatic t_restart();
        drive(1, 2'h2, 0, 6);
        drive(0, 2'h2, 0, 12);
        drive(1, 2'h2, 0, 2);
        check("restart low", rst_n, 1'b0);
        drive(0, 2'h2, 0, 0);
        measure("restart", 20);
    endtask
    initial begin
        repeat (3) @(posedge clk);
        nrst <= 1'b1;
        #1;
        measure("power up", 20);
        t_manual(0);
        t_manual(1);
        t_sense();
        t_band();
        t_restart();
        t_reset();
        final_report();
    end
endmodule
